// [verilog/rle_pkg.sv]
package rle_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_BLOCK_IRQ_ENABLE    = 6'h01;
    localparam logic [5:0] IDX_ALARM_ERROR_STATUS  = 6'h02;
    localparam logic [5:0] IDX_ALARM_ERROR_IRQ_EN  = 6'h03;
    localparam logic [5:0] IDX_IRQ_CONTROL         = 6'h04;
    localparam logic [5:0] IDX_STATUS_CLEAR        = 6'h05;
    localparam logic [5:0] IDX_LINE_STATE          = 6'h06;
    localparam logic [5:0] IDX_VIOLATION_COUNT     = 6'h07;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_VIOLATION       = 3;
    localparam int POS_LOSS_OF_SIGNAL  = 4;
    localparam int POS_BLOCK_AE_ENABLE = 1;
    localparam int POS_CLEAR_ON_READ   = 0;
    localparam int POS_LIVE_LOS        = 0;
    localparam int POS_LAST_POLARITY   = 1;

    // event order used by the status generate loop
    localparam int NUM_EVENTS = 2;
    localparam int EVT_VIOLATION = 0;
    localparam int EVT_LOSS      = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BLOCK_IRQ_ENABLE = 8'h00;
    localparam logic [7:0]  RST_AE_IRQ_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_IRQ_CONTROL      = 8'h00;
    localparam logic [15:0] RST_VIOLATION_COUNT  = 16'h0000;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    // consecutive zero bits counted before loss of signal; the next zero bit declares it
    localparam logic [7:0]  LOS_ZERO_BITS = 8'h20;

    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } rle_bus_e;

endpackage

// [verilog/rle_line_decoder.sv]
`timescale 1ns/100ps
`default_nettype none

module rle_line_decoder (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic bitStrobe,
    input  wire logic pulsePos,
    input  wire logic pulseNeg,
    output logic      violationEvt,
    output logic      losLevel,
    output logic      lastNegFf
);

    logic [7:0] zeroCntFf;
    logic       seenPulseFf;
    logic       anyPulse;

    assign anyPulse = pulsePos | pulseNeg;

    // ------------------------------------------------------------
    // alternate mark inversion check
    // ------------------------------------------------------------
    // both rails at once cannot be a legal mark, so it counts too
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            violationEvt <= 1'b0;
            lastNegFf    <= 1'b0;
            seenPulseFf  <= 1'b0;
        end else if (ce) begin
            violationEvt <= 1'b0;
            if (bitStrobe && anyPulse) begin
                violationEvt <= (pulsePos & pulseNeg)
                    | (seenPulseFf & (pulseNeg == lastNegFf));
                lastNegFf    <= pulseNeg;
                seenPulseFf  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // loss of signal, run of zeros
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zeroCntFf <= 8'h00;
            losLevel  <= 1'b0;
        end else if (ce && bitStrobe) begin
            if (anyPulse) begin
                zeroCntFf <= 8'h00;
                losLevel  <= 1'b0;
            end else if (zeroCntFf != rle_pkg::LOS_ZERO_BITS) begin
                zeroCntFf <= zeroCntFf + 8'h01;
            end else begin
                losLevel  <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [verilog/rle_irq_status.sv]
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - decode bipolar marks; a mark repeating the last polarity is a violation.
// - any violation sets status bit 3 of alarm_error_status.
// - enable bit 3 gates the violation interrupt.
// - block enable bit 1 gates every alarm/error interrupt.
// - interrupt only when both per-condition and block enables are one.
// - with clear_on_read set, reading status clears its bits and interrupt.
// - set violation or loss bits hold until read with clear_on_read set, or until written clear with it unset.
// - enable bit 4 gates the loss-of-signal interrupt.
// - loss of signal sets status bit 4.
// - status bits show a change of the condition, not its level.
module rle_irq_status (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        linePos,
    input  wire logic        lineNeg,
    input  wire logic        lineStrobe,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]  pinAsync;
    logic [2:0]  pinSync;
    logic        strobeDlyFf;
    logic        bitStrobe;
    logic        violationEvt;
    logic        losLevel;
    logic        lastNeg;
    logic        losPrevFf;
    logic        losChange;
    logic [1:0]  eventPulse;

    rle_pkg::rle_bus_e busStateFf;
    logic        accept;
    logic        rdAccept;
    logic        wrAccept;
    logic        wrBlockEn;
    logic        wrAeEn;
    logic        wrControl;
    logic        wrCount;
    logic        wrClear;
    logic [31:0] readdataFf;
    logic [31:0] nxt_readdata;

    logic [7:0]  blockIrqEnableFf;
    logic [7:0]  aeIrqEnableFf;
    logic [7:0]  irqControlFf;
    logic [15:0] violationCountFf;
    logic [7:0]  statusVec;
    logic [7:0]  clearMask;
    logic        irqFf;
    logic        nxt_irq;
    logic [1:0]  eventIrq;

    // ------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------
    function automatic logic hitReg(input logic [7:0] addr,
                                    input logic [5:0] idx);
        hitReg = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // stage 0 feeds only stage 1; logic reads stage 1 alone
    // ce low stalls these too, so the line goes unwatched meanwhile
    assign pinAsync = {lineStrobe, lineNeg, linePos};

    generate
        for (genvar si = 0; si < 3; si++) begin : gSync
            logic [1:0] stageFf;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stageFf <= 2'h0;
                end else if (ce) begin
                    stageFf <= {stageFf[0], pinAsync[si]};
                end
            end
            assign pinSync[si] = stageFf[1];
        end
    endgenerate

    // edge found after both stages, never on the raw pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeDlyFf <= 1'b0;
        end else if (ce) begin
            strobeDlyFf <= pinSync[2];
        end
    end

    // rails are sampled on the synchronised rising edge of the strobe
    assign bitStrobe = pinSync[2] & ~strobeDlyFf;

    // ------------------------------------------------------------
    // line decoder
    // ------------------------------------------------------------
    rle_line_decoder uDecoder (
        .clk          (clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .bitStrobe    (bitStrobe),
        .pulsePos     (pinSync[0]),
        .pulseNeg     (pinSync[1]),
        .violationEvt (violationEvt),
        .losLevel     (losLevel),
        .lastNegFf    (lastNeg)
    );

    // ------------------------------------------------------------
    // condition change detection
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            losPrevFf <= 1'b0;
        end else if (ce) begin
            losPrevFf <= losLevel;
        end
    end

    // loss bit flags both entry and exit of the condition
    assign losChange = losLevel ^ losPrevFf;

    assign eventPulse[rle_pkg::EVT_VIOLATION] = violationEvt;
    assign eventPulse[rle_pkg::EVT_LOSS]      = losChange;

    // ------------------------------------------------------------
    // avalon slave handshake
    // ------------------------------------------------------------
    // one wait state: request seen in idle, answered next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busStateFf <= rle_pkg::BUS_IDLE;
        end else if (ce) begin
            case (busStateFf)
                rle_pkg::BUS_IDLE: begin
                    if (read || write) begin
                        busStateFf <= rle_pkg::BUS_ACK;
                    end
                end
                rle_pkg::BUS_ACK: begin
                    busStateFf <= rle_pkg::BUS_IDLE;
                end
                default: begin
                    busStateFf <= rle_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // with ce low nothing is accepted, so the master keeps waiting
    assign accept      = ce && (busStateFf == rle_pkg::BUS_ACK)
                         && (read || write);
    assign waitrequest = (read || write) && !accept;
    assign rdAccept    = accept && read;
    assign wrAccept    = accept && write && byteenable[0];

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    // a misaligned or unmapped address hits nothing and is dropped
    assign wrBlockEn = wrAccept
                       && hitReg(address, rle_pkg::IDX_BLOCK_IRQ_ENABLE);
    assign wrAeEn    = wrAccept
                       && hitReg(address, rle_pkg::IDX_ALARM_ERROR_IRQ_EN);
    assign wrControl = wrAccept
                       && hitReg(address, rle_pkg::IDX_IRQ_CONTROL);
    assign wrCount   = wrAccept
                       && hitReg(address, rle_pkg::IDX_VIOLATION_COUNT);
    assign wrClear   = wrAccept
                       && (hitReg(address, rle_pkg::IDX_ALARM_ERROR_STATUS)
                        || hitReg(address, rle_pkg::IDX_STATUS_CLEAR));

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        if (hitReg(address, rle_pkg::IDX_BLOCK_IRQ_ENABLE)) begin
            nxt_readdata[7:0] = blockIrqEnableFf;
        end else if (hitReg(address, rle_pkg::IDX_ALARM_ERROR_STATUS)) begin
            nxt_readdata[7:0] = statusVec;
        end else if (hitReg(address, rle_pkg::IDX_ALARM_ERROR_IRQ_EN)) begin
            nxt_readdata[7:0] = aeIrqEnableFf;
        end else if (hitReg(address, rle_pkg::IDX_IRQ_CONTROL)) begin
            nxt_readdata[7:0] = irqControlFf;
        end else if (hitReg(address, rle_pkg::IDX_LINE_STATE)) begin
            nxt_readdata[rle_pkg::POS_LIVE_LOS]      = losLevel;
            nxt_readdata[rle_pkg::POS_LAST_POLARITY] = lastNeg;
        end else if (hitReg(address, rle_pkg::IDX_VIOLATION_COUNT)) begin
            nxt_readdata[15:0] = violationCountFf;
        end
    end

    // value captured in the wait cycle, stands on the accept edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdataFf <= 32'h0000_0000;
        end else if (ce) begin
            if (read && busStateFf == rle_pkg::BUS_IDLE) begin
                readdataFf <= nxt_readdata;
            end
        end
    end

    assign readdata = readdataFf;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // a refused write is still answered, only the register holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blockIrqEnableFf <= rle_pkg::RST_BLOCK_IRQ_ENABLE;
        end else if (wrBlockEn) begin
            blockIrqEnableFf <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aeIrqEnableFf <= rle_pkg::RST_AE_IRQ_ENABLE;
        end else if (wrAeEn) begin
            aeIrqEnableFf <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqControlFf <= rle_pkg::RST_IRQ_CONTROL;
        end else if (wrControl) begin
            irqControlFf <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // violation counter
    // ------------------------------------------------------------
    // saturates rather than wraps so a burst is never under-reported
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            violationCountFf <= rle_pkg::RST_VIOLATION_COUNT;
        end else if (ce) begin
            if (wrCount) begin
                violationCountFf <= {15'h0000, violationEvt};
            end else if (violationEvt && violationCountFf != 16'hFFFF) begin
                violationCountFf <= violationCountFf + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // clear mask for status bits
    // ------------------------------------------------------------
    always_comb begin
        clearMask = 8'h00;
        if (rdAccept && irqControlFf[rle_pkg::POS_CLEAR_ON_READ]
                && hitReg(address, rle_pkg::IDX_ALARM_ERROR_STATUS)) begin
            // only bits the host saw; an event in the wait cycle survives
            clearMask = readdataFf[7:0];
        end else if (wrClear && !irqControlFf[rle_pkg::POS_CLEAR_ON_READ]) begin
            clearMask = writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // sticky status bits
    // ------------------------------------------------------------
    // a new event in the clearing cycle wins over the clear
    localparam int EVT_POS [rle_pkg::NUM_EVENTS] =
        '{rle_pkg::POS_VIOLATION, rle_pkg::POS_LOSS_OF_SIGNAL};

    generate
        for (genvar gi = 0; gi < rle_pkg::NUM_EVENTS; gi++) begin : gSts
            logic stickyFf;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stickyFf <= 1'b0;
                end else if (ce) begin
                    if (eventPulse[gi]) begin
                        stickyFf <= 1'b1;
                    end else if (clearMask[EVT_POS[gi]]) begin
                        stickyFf <= 1'b0;
                    end
                end
            end
            // held here until a read clears it (clear_on_read set) or a status write does (clear_on_read unset)
            assign statusVec[EVT_POS[gi]] = stickyFf;
        end
    endgenerate

    // positions without a condition in this block read as zero
    assign statusVec[2:0] = 3'h0;
    assign statusVec[7:5] = 3'h0;

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // each condition counts only while its own enable bit is set
    generate
        for (genvar ei = 0; ei < rle_pkg::NUM_EVENTS; ei++) begin : gIrq
            assign eventIrq[ei] = statusVec[EVT_POS[ei]]
                                  & aeIrqEnableFf[EVT_POS[ei]];
        end
    endgenerate

    always_comb begin
        nxt_irq = (|eventIrq)
                  & blockIrqEnableFf[rle_pkg::POS_BLOCK_AE_ENABLE];
    end

    // registered to keep the pin glitch free; lags status by a cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqFf <= 1'b0;
        end else if (ce) begin
            irqFf <= nxt_irq;
        end
    end

    assign irq = irqFf;

endmodule

`default_nettype wire

// [tb/rle_irq_status_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module rle_irq_status_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        linePos,
    input wire logic        lineNeg,
    input wire logic        lineStrobe,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // shadows of control writes and quiet-time counters
    // ------------------------------------------------------------
    logic       blkEnFf;
    logic       corFf;
    logic [3:0] lineAgeFf;
    logic [3:0] actAgeFf;
    logic       wrAcc;
    logic       rdStatus;

    assign wrAcc    = write && !waitrequest && ce && byteenable[0];
    assign rdStatus = read && !waitrequest && address == 8'h08;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blkEnFf <= 1'b0;
            corFf   <= 1'b0;
        end else if (wrAcc && address == 8'h04) begin
            blkEnFf <= writedata[1];
        end else if (wrAcc && address == 8'h10) begin
            corFf <= writedata[0];
        end
    end

    // saturating ages: a line event can only surface a few cycles late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineAgeFf <= 4'h0;
            actAgeFf  <= 4'h0;
        end else begin
            lineAgeFf <= lineStrobe ? 4'h0
                       : lineAgeFf + {3'h0, lineAgeFf != 4'hF};
            actAgeFf  <= (lineStrobe || wrAcc) ? 4'h0
                       : actAgeFf + {3'h0, actAgeFf != 4'hF};
        end
    end

    AST_WAIT_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        (read || write) && !$past(read || write) |-> waitrequest)
        else $error("request answered without a wait cycle");
    AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        (read || write) && waitrequest && ce |=> !waitrequest)
        else $error("request not answered in the second cycle");
    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        read && !waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
        read && !waitrequest && address > 8'h1C |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_STATUS_FIELDS: assert property (@(posedge clk)
        disable iff (!rst_n) rdStatus |-> (readdata[7:0] & 8'hE7) == 8'h00)
        else $error("status bit outside the two events set");
    AST_BLOCK_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        !blkEnFf && $past(!blkEnFf) && $past(!blkEnFf, 2) |-> !irq)
        else $error("interrupt with block enable off");
    AST_COR_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        rdStatus && corFf && lineAgeFf == 4'hF |-> ##[1:3] !irq)
        else $error("status read did not drop the interrupt");
    AST_WC_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        rdStatus && !corFf && irq |=> irq [*2])
        else $error("interrupt dropped by a read without clear on read");
    AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(irq) |-> actAgeFf < 4'hC)
        else $error("interrupt rose with no line event or write");
endmodule

bind rle_irq_status rle_irq_status_asserts u_asserts (
    .clk(clk), .rst_n(rst_n), .ce(ce), .linePos(linePos), .lineNeg(lineNeg),
    .lineStrobe(lineStrobe), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));

`default_nettype wire

// [tb/rle_line_model.sv]
`timescale 1ns/100ps
`default_nettype none

module rle_line_model (
    input  wire logic clk,
    output logic      linePos,
    output logic      lineNeg,
    output logic      lineStrobe
);
    initial begin
        linePos = 1'b0;
        lineNeg = 1'b0;
        lineStrobe = 1'b0;
    end

    // rails settle before the strobe and drop with it, so no skew race
    task automatic sendBit(input logic pos, input logic neg);
        @(posedge clk);
        linePos <= pos;
        lineNeg <= neg;
        repeat (2) @(posedge clk);
        lineStrobe <= 1'b1;
        repeat (4) @(posedge clk);
        lineStrobe <= 1'b0;
        linePos <= 1'b0;
        lineNeg <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// [tb/rle_irq_status_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module rle_irq_status_bench;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        linePos;
    logic        lineNeg;
    logic        lineStrobe;
    logic [31:0] q;
    int          badCount;
    int          samplesChecked;
    int          cycleCount;
    logic [7:0]  resetAddr [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                                   8'h1C, 8'h20, 8'h05};

    rle_irq_status DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .linePos(linePos),
        .lineNeg(lineNeg), .lineStrobe(lineStrobe), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq));
    rle_line_model LINE (.clk(clk), .linePos(linePos), .lineNeg(lineNeg),
        .lineStrobe(lineStrobe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stopTest();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until the rising edge at which waitrequest is low
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        access(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0, 4'hF);
        check(q, exp);
    endtask

    // irq flop follows the registers one edge after the accept
    task automatic chkIrq(input logic exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic mark(input logic p, input logic n);
        LINE.sendBit(p, n);
        repeat (12) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount > 20000) begin
            badCount++;
            stopTest();
        end
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        badCount = 0;
        samplesChecked = 0;
        cycleCount = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (resetAddr[i]) rd(resetAddr[i], 32'h0);
        wr(8'h04, 32'h02);
        wr(8'h0C, 32'h18);
        access(1'b1, 8'h0C, 32'h00, 4'h0);
        rd(8'h04, 32'h02);
        rd(8'h0C, 32'h18);
        mark(1'b1, 1'b0);
        mark(1'b0, 1'b1);
        mark(1'b1, 1'b0);
        rd(8'h08, 32'h00);
        chkIrq(1'b0);
        mark(1'b1, 1'b0);
        chkIrq(1'b1);
        rd(8'h08, 32'h08);
        chkIrq(1'b1);
        wr(8'h14, 32'h08);
        rd(8'h08, 32'h00);
        chkIrq(1'b0);
        wr(8'h0C, 32'h10);
        mark(1'b0, 1'b1);
        mark(1'b0, 1'b1);
        chkIrq(1'b0);
        wr(8'h0C, 32'h18);
        chkIrq(1'b1);
        wr(8'h04, 32'h00);
        chkIrq(1'b0);
        wr(8'h04, 32'h02);
        chkIrq(1'b1);
        rd(8'h08, 32'h08);
        wr(8'h08, 32'h08);
        chkIrq(1'b0);
        wr(8'h10, 32'h01);
        mark(1'b1, 1'b0);
        mark(1'b1, 1'b0);
        chkIrq(1'b1);
        rd(8'h08, 32'h08);
        chkIrq(1'b0);
        rd(8'h08, 32'h00);
        repeat (34) mark(1'b0, 1'b0);
        rd(8'h18, 32'h01);
        chkIrq(1'b1);
        rd(8'h08, 32'h10);
        wr(8'h0C, 32'h08);
        mark(1'b0, 1'b1);
        chkIrq(1'b0);
        rd(8'h08, 32'h10);
        ce <= 1'b0;
        fork
            wr(8'h0C, 32'h18);
            begin
                repeat (6) @(posedge clk);
                check({31'h0, irq}, 32'h0);
                ce <= 1'b1;
            end
        join
        rd(8'h0C, 32'h18);
        rd(8'h1C, 32'h03);
        stopTest();
    end
endmodule

`default_nettype wire
